// ### core/sys_protect_pkg.sv
package sys_protect_pkg;

    // register byte addresses on the apb window
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_SERVICE = 8'h04;
    localparam logic [7:0] ADDR_CAUSE   = 8'h08;
    localparam logic [7:0] ADDR_FREEZE  = 8'h0C;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;

    // service sequence bytes
    localparam logic [7:0] SERVICE_ARM  = 8'h55;
    localparam logic [7:0] SERVICE_FIRE = 8'hAA;

    // watchdog prescaler divides by 512
    localparam int         PRESCALE_W   = 9;
    localparam logic [8:0] PRESCALE_TOP = 9'h1FF;

    // timeout divider exponents after the optional prescaler, per timing code
    localparam int         WD_CNT_W     = 15;
    localparam logic [3:0] WD_EXP [4]   = '{4'h9, 4'hB, 4'hD, 4'hF};

    // bus monitor limits in system clocks, per timing code
    localparam int         BM_CNT_W     = 7;
    localparam logic [6:0] BM_LIMIT [4] = '{7'h40, 7'h20, 7'h10, 7'h08};

    // protection control layout, bit 7 down to bit 0
    typedef struct packed {
        logic       watchdog_enable;
        logic       watchdog_prescale;
        logic [1:0] watchdog_timing;
        logic       halt_monitor_enable;
        logic       external_bus_monitor_enable;
        logic [1:0] bus_monitor_timing;
    } ctrl_t;

    // protection control reset values (prescale comes from the strap)
    localparam logic       RST_WD_ENABLE  = 1'b1;
    localparam logic [1:0] RST_WD_TIMING  = 2'h0;
    localparam logic       RST_HALT_EN    = 1'b1;
    localparam logic       RST_EXT_BM_EN  = 1'b0;
    localparam logic [1:0] RST_BM_TIMING  = 2'h0;

    // reset cause layout, bit 7 down to bit 0
    typedef struct packed {
        logic       external;
        logic       power_up;
        logic       watchdog;
        logic       halt;
        logic [3:0] unused;
    } cause_t;

    // freeze control layout
    localparam int FRZ_TIMERS_BIT = 0;
    localparam int FRZ_BM_BIT     = 1;

    // status layout
    localparam int STAT_ARMED_BIT  = 0;
    localparam int STAT_BUS_ERROR_BIT   = 1;
    localparam int STAT_CODE_LSB   = 2;
    localparam int STAT_LOCKED_BIT = 5;
    localparam int STAT_TEST_BIT   = 6;

    // view of the internal bus cycle being timed
    typedef struct packed {
        logic cycle_active;
        logic cycle_external;
        logic cycle_by_external_master;
        logic interrupt_acknowledge_cycle;
        logic data_size_acknowledge;
        logic autovector_request;
        logic arbitration_done;
        logic arbitration_won;
    } bus_view_t;

    typedef enum logic [0:0] {
        SVC_IDLE  = 1'b0,
        SVC_ARMED = 1'b1
    } svc_state_t;

endpackage

// ### core/system_protection_monitors.sv
`timescale 1ns/1ps
// Behaviour
// RULE_01: control register write-once outside test mode
// RULE_02: test mode allows control writes always
// RULE_03: enable bit turns watchdog on/off
// RULE_04: prescale bit divides watchdog clock by 512
// RULE_05: prescale resets to inverse of mode pin
// RULE_06: code selects timeout of 2^9..2^24 periods
// RULE_07: new timeout applies after service sequence
// RULE_08: halt enable bit gates halt reset
// RULE_09: external enable extends monitoring to external cycles
// RULE_10: timing field gives 64/32/16/8 clocks
// RULE_11: count unanswered clocks, raise bus error
// RULE_12: internal always; external only self-started
// RULE_13: external masters need own monitor
// RULE_14: halt assertion causes reset unless inhibited
// RULE_15: halt reset sets halt cause flag
// RULE_16: no arbitration in acknowledge raises error
// RULE_17: enabled watchdog resets on timeout
// RULE_18: software writes 0x55 then 0xAA
// RULE_19: service register writable, reads zero
// RULE_20: watchdog reset sets watchdog cause flag
// RULE_21: freeze stops watchdog when enabled
// RULE_22: freeze disables bus monitor when enabled
// RULE_23: counter restarts on service or reset
// RULE_24: other byte leaves sequence unfinished
module system_protection_monitors
    import sys_protect_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        power_up,
    // pins
    input  wire logic        test_mode,
    input  wire logic        clock_mode_select_pin,
    input  wire logic        osc_in,
    // core side
    input  wire logic        freeze,
    input  wire logic        halt_in,
    input  wire bus_view_t   bus,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // monitor outputs
    output logic             bus_error,
    output logic             watchdog_reset,
    output logic             halt_reset
);

    // test and oscillator pins are asynchronous to clk and may go
    // metastable, so each passes three flops before use
    // pin synchronisers, three stages each
    logic [2:0]  test_sync_q;
    logic [2:0]  mode_sync_q;
    logic [2:0]  osc_sync_q;
    logic        test_q;
    logic        mode_q;
    logic        osc_q;
    logic        osc_tick;

    // registers and state
    ctrl_t       ctrl_q;
    logic        locked_q;
    logic [1:0]  frz_q;
    cause_t      cause_q;
    logic        active_prescale_q;
    logic [1:0]  active_timing_q;
    svc_state_t  svc_q;
    logic [PRESCALE_W-1:0] presc_q;
    logic [WD_CNT_W-1:0]   wd_cnt_q;
    logic [BM_CNT_W-1:0]   bm_cnt_q;
    logic        bus_error_q;
    logic        wd_rst_q;
    logic        halt_rst_q;
    logic        halt_prev_q;
    logic        resetn_q;
    logic        wd_pending_q;
    logic        halt_pending_q;

    // decoded bus strobes
    logic        wr_access;
    logic        setup;
    logic        wr_ctrl;
    logic        wr_service;
    logic        wr_freeze;
    logic        service_done;

    // watchdog and monitor terms
    logic        wd_run;
    logic        div_tick;
    logic [WD_CNT_W-1:0] wd_mask;
    logic        wd_expire;
    logic        bm_frozen;
    logic        bm_watch;
    logic        bm_answered;
    logic        bm_timeout;
    logic        spurious;

    // three-flop synchronisers; stage 1 feeds only stage 2
    always_ff @(posedge clk) begin
        if (!resetn) begin
            test_sync_q <= 3'h0;
            osc_sync_q  <= 3'h0;
        end else begin
            test_sync_q <= {test_sync_q[1:0], test_mode};
            osc_sync_q  <= {osc_sync_q[1:0], osc_in};
        end
    end

    // mode pin chain keeps running in reset so the strap is seen at release
    // the strap has no reset of its own; only its level in reset matters
    always_ff @(posedge clk) begin
        mode_sync_q <= {mode_sync_q[1:0], clock_mode_select_pin};
    end

    // filtered levels change only when stages two and three agree
    // a one-cycle glitch on a pin never reaches the logic
    always_ff @(posedge clk) begin
        if (!resetn) begin
            test_q <= 1'b0;
            osc_q  <= 1'b0;
        end else begin
            if (test_sync_q[1] == test_sync_q[2]) begin
                test_q <= test_sync_q[2];
            end
            if (osc_sync_q[1] == osc_sync_q[2]) begin
                osc_q <= osc_sync_q[2];
            end
        end
    end

    // strap level, tracked through reset and frozen afterwards
    always_ff @(posedge clk) begin
        if (!resetn && (mode_sync_q[1] == mode_sync_q[2])) begin
            mode_q <= mode_sync_q[2];
        end
    end

    // one tick per rising edge of the oscillator input
    // the filtered level lags the chain, so a tick lasts one clock
    assign osc_tick = osc_sync_q[1] && osc_sync_q[2] && !osc_q;

    // apb decode; writes take effect at the access edge
    // a locked control write is dropped silently, with no error answer
    // every register answers at once, so pready is tied high
    assign setup      = psel && !penable;
    assign wr_access  = psel && penable && pwrite;
    assign wr_ctrl    = wr_access && (paddr == ADDR_CTRL) && (test_q || !locked_q); // RULE_01 RULE_02
    assign wr_service = wr_access && (paddr == ADDR_SERVICE); // RULE_19
    assign wr_freeze  = wr_access && (paddr == ADDR_FREEZE);
    assign service_done = wr_service && (svc_q == SVC_ARMED)
                          && (pwdata[7:0] == SERVICE_FIRE);
    assign pready     = 1'b1;

    // protection control register and its write-once lock
    // any reset clears the lock; a test mode write leaves it as it was
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_q.watchdog_enable             <= RST_WD_ENABLE;
            ctrl_q.watchdog_prescale           <= ~mode_q; // RULE_05
            ctrl_q.watchdog_timing             <= RST_WD_TIMING;
            ctrl_q.halt_monitor_enable         <= RST_HALT_EN;
            ctrl_q.external_bus_monitor_enable <= RST_EXT_BM_EN;
            ctrl_q.bus_monitor_timing          <= RST_BM_TIMING;
            locked_q                           <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_q   <= ctrl_t'(pwdata[7:0]);
            locked_q <= locked_q || !test_q; // RULE_01
        end
    end

    // freeze control register
    // bit 0 holds the watchdog, bit 1 the bus monitor, while frozen
    always_ff @(posedge clk) begin
        if (!resetn) begin
            frz_q <= 2'h0;
        end else if (wr_freeze) begin
            frz_q <= pwdata[1:0];
        end
    end

    // service sequence: 0x55 arms, 0xAA fires, anything else is ignored
    // a repeated 0x55 stays armed; other accesses in between do no harm
    always_ff @(posedge clk) begin
        if (!resetn) begin
            svc_q <= SVC_IDLE;
        end else if (wr_service) begin
            case (svc_q)
                SVC_IDLE: begin
                    if (pwdata[7:0] == SERVICE_ARM) begin
                        svc_q <= SVC_ARMED;
                    end
                end
                SVC_ARMED: begin
                    if (pwdata[7:0] == SERVICE_FIRE) begin
                        svc_q <= SVC_IDLE;
                    end
                end
                default: begin
                    svc_q <= SVC_IDLE;
                end
            endcase
        end
    end

    // timeout selection in force, updated only by a completed service
    // a new code stays dormant until serviced, so a runaway program
    // cannot change the period with a single stray write
    always_ff @(posedge clk) begin
        if (!resetn) begin
            active_prescale_q <= ~mode_q; // RULE_05
            active_timing_q   <= RST_WD_TIMING;
        end else if (service_done) begin
            active_prescale_q <= ctrl_q.watchdog_prescale; // RULE_07
            active_timing_q   <= ctrl_q.watchdog_timing; // RULE_07
        end
    end

    // watchdog clocking: optional divide by 512 ahead of the divider
    // the mask is all ones below the selected exponent
    assign wd_run   = ctrl_q.watchdog_enable && !(freeze && frz_q[FRZ_TIMERS_BIT]); // RULE_03 RULE_21
    assign div_tick = osc_tick && (!active_prescale_q || (presc_q == PRESCALE_TOP)); // RULE_04
    assign wd_mask  = WD_CNT_W'((16'h0001 << WD_EXP[active_timing_q]) - 16'h0001); // RULE_06
    assign wd_expire = wd_run && div_tick && (wd_cnt_q == wd_mask); // RULE_17

    // prescaler, held with the watchdog
    // a service clears it as well, so the full period restarts
    always_ff @(posedge clk) begin
        if (!resetn || service_done) begin
            presc_q <= '0;
        end else if (wd_run && osc_tick) begin
            presc_q <= presc_q + 9'h001;
        end
    end

    // timeout divider; a service or a timeout restarts the full period
    always_ff @(posedge clk) begin
        if (!resetn || service_done || wd_expire) begin
            wd_cnt_q <= '0; // RULE_23 RULE_24
        end else if (wd_run && div_tick) begin
            wd_cnt_q <= wd_cnt_q + 15'h0001; // RULE_17
        end
    end

    // watchdog reset request, one cycle
    // the pulse is looped back into resetn outside this block
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wd_rst_q <= 1'b0;
        end else begin
            wd_rst_q <= wd_expire; // RULE_17
        end
    end

    // halt monitor: rising halt requests a reset when enabled
    // only the rising edge counts; halt_prev_q clears in reset, so a halt still high at release counts again
    always_ff @(posedge clk) begin
        if (!resetn) begin
            halt_prev_q <= 1'b0;
            halt_rst_q  <= 1'b0;
        end else begin
            halt_prev_q <= halt_in;
            halt_rst_q  <= halt_in && !halt_prev_q && ctrl_q.halt_monitor_enable; // RULE_08 RULE_14
        end
    end

    // bus monitor eligibility and answer
    // external cycles of an external master are never timed here; such a system
    // must watch its external bus itself and clear the external enable
    assign bm_frozen   = freeze && frz_q[FRZ_BM_BIT]; // RULE_22
    assign bm_watch    = bus.cycle_active && !bm_frozen
                         && (!bus.cycle_external // RULE_12
                             || (ctrl_q.external_bus_monitor_enable // RULE_09
                                 && !bus.cycle_by_external_master)); // RULE_12 RULE_13
    assign bm_answered = bus.interrupt_acknowledge_cycle ? bus.autovector_request
                                                         : bus.data_size_acknowledge; // RULE_11
    assign bm_timeout  = bm_watch && !bm_answered
                         && (bm_cnt_q == BM_LIMIT[ctrl_q.bus_monitor_timing]); // RULE_10 RULE_11
    assign spurious    = bus.cycle_active && bus.interrupt_acknowledge_cycle
                         && bus.arbitration_done && !bus.arbitration_won; // RULE_16

    // response-time counter, restarted by an answer or the end of a cycle
    // the count stops at the limit, so a long cycle cannot wrap it
    always_ff @(posedge clk) begin
        if (!resetn || !bus.cycle_active || bm_answered) begin
            bm_cnt_q <= '0;
        end else if (bm_watch && !bus_error_q && !bm_timeout) begin
            bm_cnt_q <= bm_cnt_q + 7'h01; // RULE_11
        end
    end

    // bus error holds until the cycle ends
    // a new timeout wins over the clear at the end of a cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bus_error_q <= 1'b0;
        end else if (bm_timeout || spurious) begin
            bus_error_q <= 1'b1; // RULE_11 RULE_16
        end else if (!bus.cycle_active) begin
            bus_error_q <= 1'b0;
        end
    end

    // reset edge tracker for the cause register
    always_ff @(posedge clk) begin
        resetn_q <= resetn;
    end

    // pending cause survives the reset it requested, cleared at release
    // the request pulse comes while resetn is still high, so the cause
    // is parked here until reset is entered
    always_ff @(posedge clk) begin
        if (power_up) begin
            wd_pending_q   <= 1'b0;
            halt_pending_q <= 1'b0;
        end else if (wd_rst_q || halt_rst_q) begin
            wd_pending_q   <= wd_pending_q || wd_rst_q;
            halt_pending_q <= halt_pending_q || halt_rst_q;
        end else if (resetn && !resetn_q) begin
            wd_pending_q   <= 1'b0;
            halt_pending_q <= 1'b0;
        end
    end

    // cause register, loaded on entry to reset; one flag at a time
    // power-up overrides every other cause
    always_ff @(posedge clk) begin
        if (power_up) begin
            cause_q          <= '0;
            cause_q.power_up <= 1'b1;
        end else if (!resetn && resetn_q) begin
            cause_q          <= '0;
            cause_q.watchdog <= wd_pending_q; // RULE_20
            cause_q.halt     <= halt_pending_q && !wd_pending_q; // RULE_15
            cause_q.external <= !wd_pending_q && !halt_pending_q;
        end
    end

    // read data and error answer, captured in the setup phase
    // reads have no side effects, so capturing early is safe
    always_ff @(posedge clk) begin
        if (!resetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            case (paddr)
                ADDR_CTRL:    prdata[7:0] <= ctrl_q;
                ADDR_SERVICE: prdata      <= 32'h0000_0000; // RULE_19
                ADDR_CAUSE:   prdata[7:0] <= cause_q;
                ADDR_FREEZE:  prdata[1:0] <= frz_q;
                ADDR_STATUS: begin
                    prdata[STAT_ARMED_BIT]  <= (svc_q == SVC_ARMED);
                    prdata[STAT_BUS_ERROR_BIT]   <= bus_error_q;
                    prdata[STAT_CODE_LSB+:3] <= {active_prescale_q, active_timing_q};
                    prdata[STAT_LOCKED_BIT] <= locked_q;
                    prdata[STAT_TEST_BIT]   <= test_q;
                end
                default: begin
                    pslverr <= 1'b1;
                end
            endcase
        end
    end

    // registered monitor outputs
    // all three leave flops, so no glitch reaches the reset logic
    assign bus_error      = bus_error_q;
    assign watchdog_reset = wd_rst_q;
    assign halt_reset     = halt_rst_q;

endmodule

// ### verification/sys_protect_monitor.sv
`timescale 1ns/1ps
module sys_protect_monitor
    import sys_protect_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    // monitors
    input wire logic        halt_in,
    input wire bus_view_t   bus,
    input wire logic        bus_error,
    input wire logic        watchdog_reset,
    input wire logic        halt_reset
);
    logic [7:0] act_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // length of the current bus cycle so far
    always_ff @(posedge clk) begin
        if (!resetn || !bus.cycle_active) act_q <= 8'h00;
        else if (act_q != 8'hFF) act_q <= act_q + 8'h01;
    end
    property p_ready; psel && penable |-> pready; endproperty
    a_ready: assert property (p_ready)
        else $error("apb access not ready");
    property p_svc_zero;
        psel && !penable && !pwrite && paddr == ADDR_SERVICE |=> prdata == 32'h0;
    endproperty
    a_svc_zero: assert property (p_svc_zero)
        else $error("service read not zero");
    property p_halt; halt_reset |-> $past(halt_in); endproperty
    a_halt: assert property (p_halt)
        else $error("halt reset without halt");
    property p_wd_pulse; watchdog_reset |=> !watchdog_reset; endproperty
    a_wd_pulse: assert property (p_wd_pulse)
        else $error("watchdog reset too long");
    // eight clocks is the shortest limit
    property p_bus_error_min;
        $rose(bus_error) && !$past(bus.arbitration_done) |-> act_q >= 8'h08;
    endproperty
    a_bus_error_min: assert property (p_bus_error_min)
        else $error("bus error too early");
    property p_bus_error_drop; !bus.cycle_active |=> !bus_error; endproperty
    a_bus_error_drop: assert property (p_bus_error_drop)
        else $error("bus error outlives cycle");
    property p_spur;
        bus.cycle_active && bus.interrupt_acknowledge_cycle && bus.arbitration_done
            && !bus.arbitration_won |=> bus_error;
    endproperty
    a_spur: assert property (p_spur)
        else $error("spurious acknowledge not flagged");
    property p_xm;
        bus.cycle_active && bus.cycle_by_external_master
            && !bus.interrupt_acknowledge_cycle |=> !$rose(bus_error);
    endproperty
    a_xm: assert property (p_xm)
        else $error("external master cycle timed");
endmodule

// ### verification/cycle_responder.sv
`timescale 1ns/1ps
module cycle_responder
    import sys_protect_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // request: kind is {ack cycle, external, external master, wins}
    input  wire logic       go,
    input  wire logic [6:0] delay,
    input  wire logic [3:0] kind,
    input  wire logic       bus_error,
    // cycle seen by the monitor
    output bus_view_t       bus
);
    logic       act_q;
    logic       pat_q;
    logic [6:0] n_q;
    logic [3:0] kind_q;
    wire        ans = act_q && delay != 7'h00 && n_q >= delay;
    // a cycle ends on its answer, on bus error or by abort
    always_ff @(posedge clk) begin
        pat_q <= resetn ? ~pat_q : 1'b0;
        if (!resetn) begin
            act_q  <= 1'b0;
            n_q    <= 7'h00;
            kind_q <= 4'h0;
        end else if (go) begin
            act_q  <= 1'b1;
            n_q    <= 7'h00;
            kind_q <= kind;
        end else if (act_q) begin
            n_q <= n_q + 7'h01;
            if (bus_error || n_q == 7'h78 || (delay != 7'h00 && n_q == delay + 7'h01))
                act_q <= 1'b0;
        end
    end
    // answer lines toggle when no cycle is open
    assign bus = {act_q, kind_q[2], kind_q[1], kind_q[3],
                  act_q ? ans && !kind_q[3] : pat_q,
                  act_q ? ans && kind_q[3] : ~pat_q,
                  act_q && kind_q[3] && n_q == 7'h01, kind_q[0]};
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
module tb
    import sys_protect_pkg::*;
;
    logic        clk = 1'b0, osc_in = 1'b0, rst_q = 1'b0, power_up = 1'b1, strap = 1'b0;
    logic        test_mode = 1'b0, freeze = 1'b0, halt_in = 1'b0, go = 1'b0, err_q;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lock_m;
    logic        pready, pslverr, bus_error, watchdog_reset, halt_reset;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_q, ctrl_m, rnd_q = 32'h9D7B;
    logic [6:0]  delay = 7'h00;
    logic [3:0]  kind = 4'h0, lb_q = 4'h0;
    bus_view_t   bus;
    wire         resetn = rst_q && lb_q == 4'h0;
    int          num_errors = 0, total_checks = 0, wd_cnt = 0, ht_cnt = 0, n;
    system_protection_monitors DUT (.clk, .resetn, .power_up, .test_mode,
        .clock_mode_select_pin(strap), .osc_in, .freeze, .halt_in, .bus, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .bus_error, .watchdog_reset,
        .halt_reset);
    cycle_responder partner (.clk, .resetn, .go, .delay, .kind, .bus_error, .bus);
    always #4 clk = ~clk;
    always #32 osc_in = ~osc_in;
    // monitor resets are looped back into resetn
    always @(posedge clk) begin
        if (watchdog_reset === 1'b1) wd_cnt++;
        if (halt_reset === 1'b1) ht_cnt++;
        if (watchdog_reset === 1'b1 || halt_reset === 1'b1) lb_q <= 4'h6;
        else if (lb_q != 4'h0) lb_q <= lb_q - 4'h1;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic void mreset(input logic s);
        ctrl_m = {24'h0, 1'b1, ~s, 2'b00, 1'b1, 1'b0, 2'b00};
        lock_m = 1'b0;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // write-once control unless in test mode
        if (w && a == ADDR_CTRL && (test_mode || !lock_m)) begin
            ctrl_m = d & 32'hFF;
            lock_m = lock_m | !test_mode;
        end
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk(nm, e, rd_q);
    endtask
    task automatic rst(input logic s, input logic pu);
        rst_q <= 1'b0;
        strap <= s;
        power_up <= pu;
        repeat (16) @(posedge clk);
        rst_q <= 1'b1;
        power_up <= 1'b0;
        mreset(s);
    endtask
    task automatic svc;
        apb(ADDR_SERVICE, 1'b1, {24'h0, SERVICE_ARM});
        apb(ADDR_SERVICE, 1'b1, {24'h0, SERVICE_FIRE});
    endtask
    task automatic halt_pulse;
        @(posedge clk);
        halt_in <= 1'b1;
        repeat (3) @(posedge clk);
        halt_in <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    // wait for a watchdog reset, then for the loopback to finish
    task automatic wait_wd(input int lim);
        int k;
        k = wd_cnt;
        n = 0;
        while (wd_cnt == k && n < lim) begin
            @(posedge clk);
            n++;
        end
        repeat (12) @(posedge clk);
        mreset(strap);
    endtask
    // one monitored cycle; n is the wait until bus error, 0 if none
    task automatic cyc(input logic [6:0] dl, input logic [3:0] kd, input int e);
        int k;
        @(posedge clk);
        go <= 1'b1;
        delay <= dl;
        kind <= kd;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        for (k = 1; k < 200 && (k < 3 || bus.cycle_active === 1'b1); k++) begin
            @(posedge clk);
            if (bus_error === 1'b1 && n == 0) n = k;
        end
        chk("cycle_end", 32'h0, 32'(k >= 200));
        if (e >= 0) chk("bus_error", 32'(e != 0), 32'(n != 0));
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        conclude;
    end
    initial begin
        rst(1'b0, 1'b1);
        rd("ctrl", ADDR_CTRL, ctrl_m);
        rd("cause", ADDR_CAUSE, 32'h40);
        rd("service", ADDR_SERVICE, 32'h0);
        apb(8'h40, 1'b0, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err_q});
        apb(ADDR_CTRL, 1'b1, 32'h83);
        apb(ADDR_CTRL, 1'b1, 32'hFF);
        rd("ctrl", ADDR_CTRL, ctrl_m);
        rd("status", ADDR_STATUS, 32'h30);
        rnd_q = xs(rnd_q);
        apb(ADDR_SERVICE, 1'b1, {24'h0, SERVICE_ARM});
        apb(ADDR_SERVICE, 1'b1, rnd_q & 32'h3F);
        rd("status", ADDR_STATUS, 32'h31);
        apb(ADDR_SERVICE, 1'b1, {24'h0, SERVICE_FIRE});
        rd("status", ADDR_STATUS, 32'h20);
        halt_pulse;
        chk("halt_reset", 32'h0, ht_cnt);
        wait_wd(6000);
        chk("wd_time", 32'h1, 32'(n >= 4060 && n <= 4130));
        rd("cause", ADDR_CAUSE, 32'h20);
        apb(ADDR_FREEZE, 1'b1, 32'h1);
        apb(ADDR_CTRL, 1'b1, 32'h88);
        svc;
        repeat (2000) @(posedge clk);
        svc;
        repeat (3000) @(posedge clk);
        chk("wd_count", 32'h1, wd_cnt);
        freeze <= 1'b1;
        repeat (5000) @(posedge clk);
        chk("wd_count", 32'h1, wd_cnt);
        freeze <= 1'b0;
        wait_wd(3000);
        chk("wd_rest", 32'h1, 32'(n >= 1060 && n <= 1130));
        halt_pulse;
        mreset(strap);
        chk("halt_reset", 32'h1, ht_cnt);
        rd("cause", ADDR_CAUSE, 32'h10);
        test_mode <= 1'b1;
        repeat (8) @(posedge clk);
        for (int c = 0; c < 4; c++) begin
            apb(ADDR_CTRL, 1'b1, 32'h04 | c);
            rd("ctrl", ADDR_CTRL, ctrl_m);
            cyc(7'h00, 4'h0, -1);
            chk("latency", 32'h1, 32'(n >= (64 >> c) && n <= (64 >> c) + 3));
        end
        rnd_q = xs(rnd_q);
        cyc(7'(1 + rnd_q % 6), 4'b0000, 0);
        cyc(7'h00, 4'b1000, 1);
        cyc(7'h03, 4'b1001, 0);
        cyc(7'h00, 4'b0100, 1);
        cyc(7'h00, 4'b0110, 0);
        apb(ADDR_FREEZE, 1'b1, 32'h2);
        freeze <= 1'b1;
        cyc(7'h00, 4'b0000, 0);
        freeze <= 1'b0;
        apb(ADDR_CTRL, 1'b1, 32'h03);
        cyc(7'h00, 4'b0100, 0);
        test_mode <= 1'b0;
        rst(1'b1, 1'b0);
        rd("ctrl", ADDR_CTRL, ctrl_m);
        conclude;
    end
endmodule
bind system_protection_monitors sys_protect_monitor mon (.clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pready, .prdata, .halt_in, .bus, .bus_error, .watchdog_reset, .halt_reset);
